// ### lld_map.svh
// Clock rate, currents, reset values and timing figures of the line-loss discharge sequencer.
`ifndef LLD_MAP_SVH
`define LLD_MAP_SVH

// Clock rate in kHz, so that one millisecond is this many cycles.
`define LLD_CLK_KHZ          20000
`define LLD_CLK_CYC_PER_MS   20000

// Times in milliseconds.
`define LLD_STEP_MS          12
`define LLD_LAST_STEP_MS     48
`define LLD_WINDOW_MS        84
`define LLD_DISCHARGE_MS     300
`define LLD_BLANK_MS         700
`define LLD_WAIT_MS          700

// Currents in microamperes.
`define LLD_SHORT_TEST_UA    80
`define LLD_LEVEL0_UA        400
`define LLD_LEVEL1_UA        775
`define LLD_LEVEL2_UA        1200
`define LLD_LEVEL3_UA        1600
`define LLD_DISCHARGE_UA     2000

// Staircase index values and reset values.
`define LLD_LEVEL_FIRST      2'h0
`define LLD_LEVEL_LAST       2'h3
`define LLD_CUR_RST          12'h000

`endif

// ### lld_pkg.sv
// Types shared by the line-loss discharge sequencer.
package lld_pkg;

  // Comparator and supply levels arriving from the analog side.
  typedef struct packed {
    logic run;
    logic vdd_rst;
    logic vdd_on;
    logic pin_low;
    logic line_zero_cross_detect;
  } lld_pins_t;

  // Drive demands to the line-sense current sources.
  typedef struct packed {
    logic        short_src;
    logic        test_en;
    logic [1:0]  level;
    logic        discharge_en;
    logic [11:0] current_ua;
  } lld_drive_t;

  // Sequencer states, one-hot.
  typedef enum logic [6:0] {
    LLD_ST_IDLE      = 7'h01,
    LLD_ST_SHORTTEST = 7'h02,
    LLD_ST_DETECT    = 7'h04,
    LLD_ST_WAIT      = 7'h08,
    LLD_ST_DISCHARGE = 7'h10,
    LLD_ST_BLANK     = 7'h20,
    LLD_ST_OFF       = 7'h40
  } lld_state_t;

endpackage : lld_pkg

// ### lld_seq.sv
// Line-sense sequencer: staircase line detection, discharge burst and fault latch.
`timescale 1ns/10ps
`default_nettype none
`include "lld_map.svh"

// How it works
// - A rising crossing of the zero-cross comparator counts as proof that the line is present.
// - With no crossing in the 84 ms window the discharge runs at most 300 ms, then 700 ms of blanking follow.
// - The discharge current is enabled only in the discharge state reached by the loss criteria.
// - The window holds a four-level staircase and each of the first three levels steps up after 12 ms.
// - The fourth level is held 48 ms and its expiry without a crossing starts the discharge.
// - A crossing in the window or the discharge ends it at once and starts a 700 ms wait with no current; crossings in wait or blanking leave the state unchanged.
// - Confirmed loss sets the line-loss latch as the discharge starts; the latch permits the fault latch clear.
// - A set fault latch stops switching and cycles the supply while the sequencer keeps running.
// - Once the supply reaches its start threshold the pins source an 80 uA short test current.
// - A pin below 4 V when run first goes high disables the whole function and its currents.
// - With the function disabled the fault latch clears only after the supply logic reset level.
// - The second staircase level is 775 uA.
module lld_seq #(
  parameter int unsigned STEP_CYC  = `LLD_STEP_MS * `LLD_CLK_CYC_PER_MS,
  parameter int unsigned LAST_CYC  = `LLD_LAST_STEP_MS * `LLD_CLK_CYC_PER_MS,
  parameter int unsigned DIS_CYC   = `LLD_DISCHARGE_MS * `LLD_CLK_CYC_PER_MS,
  parameter int unsigned BLANK_CYC = `LLD_BLANK_MS * `LLD_CLK_CYC_PER_MS,
  parameter int unsigned WAIT_CYC  = `LLD_WAIT_MS * `LLD_CLK_CYC_PER_MS,
  parameter int unsigned LEVEL0_UA = `LLD_LEVEL0_UA,
  parameter int unsigned LEVEL2_UA = `LLD_LEVEL2_UA,
  parameter int unsigned LEVEL3_UA = `LLD_LEVEL3_UA
) (
  // Clock and reset.
  input  wire logic           clock_i,
  input  wire logic           sys_rst_i,
  // Asynchronous comparator and supply levels.
  input  wire lld_pkg::lld_pins_t pins_i,
  // Protection fault request, same clock.
  input  wire logic           fault_set_i,
  // Current source drive.
  output lld_pkg::lld_drive_t drive_o,
  // Status and converter control.
  output logic                line_loss_latch_o,
  output logic                fault_latch_o,
  output logic                switching_en_o,
  output logic                supply_cycle_o,
  output logic                function_off_o,
  output logic [6:0]          state_o
);
  import lld_pkg::*;

  // Counts must be at least one cycle and fit the timer.
  localparam int unsigned MAX_CYC = 32'h3FFF_FFFF;
  generate
    if (STEP_CYC < 1 || LAST_CYC < 1 || DIS_CYC < 1 || BLANK_CYC < 1 || WAIT_CYC < 1 ||
        STEP_CYC > MAX_CYC || LAST_CYC > MAX_CYC || DIS_CYC > MAX_CYC ||
        BLANK_CYC > MAX_CYC || WAIT_CYC > MAX_CYC)
    begin : g_bad_cnt
      $error("lld_seq: every timing count must lie between one cycle and the timer width");
    end
    if (LEVEL0_UA > 4095 || LEVEL2_UA > 4095 || LEVEL3_UA > 4095)
    begin : g_big_ua
      $error("lld_seq: a level current exceeds twelve bits");
    end
  endgenerate
  localparam int unsigned PW = $bits(lld_pins_t);
  lld_pins_t   meta_q;
  lld_pins_t   sync_q;
  lld_state_t  state_q;
  lld_state_t  state_d;
  logic        lzc_prev_q, run_prev_q, vdd_on_prev_q, vdd_rst_prev_q;
  logic        lzc_event, run_first, vdd_rst_event_q, run_seen_q;
  logic        timer_done, loss_q, fault_q, fault_clr;
  logic [1:0]  level_q;
  logic [11:0] level_ua;
  logic [31:0] timer_q;
  logic [31:0] limit;
  // Two-flop synchroniser per bit; the first stage feeds only the second.
  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++)
    begin : g_sync
      always_ff @(posedge clock_i)
      begin
        if (sys_rst_i)
        begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end
        else
        begin
          meta_q[gi] <= pins_i[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // Edge history of the synchronised levels.
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      lzc_prev_q    <= 1'b0;
      run_prev_q    <= 1'b0;
      vdd_on_prev_q <= 1'b0;
    end
    else
    begin
      lzc_prev_q    <= sync_q.line_zero_cross_detect;
      run_prev_q    <= sync_q.run;
      vdd_on_prev_q <= sync_q.vdd_on;
    end
  end
  // crossing event.
  // Only the rising crossing counts, so a pin parked above threshold cannot fake repeated detections.
  assign lzc_event = sync_q.line_zero_cross_detect & ~lzc_prev_q;
  // First rise of run since reset; later rises are ignored.
  assign run_first = sync_q.run & ~run_prev_q & ~run_seen_q;
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      run_seen_q <= 1'b0;
    end
    else if (run_first)
    begin
      run_seen_q <= 1'b1;
    end
  end
  // Logic reset level of the supply, taken as a one-cycle event on its rising edge.
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      vdd_rst_prev_q  <= 1'b0;
      vdd_rst_event_q <= 1'b0;
    end
    else
    begin
      vdd_rst_prev_q  <= sync_q.vdd_rst;
      vdd_rst_event_q <= sync_q.vdd_rst & ~vdd_rst_prev_q;
    end
  end

  // Expiry limit of the running phase; the fourth level uses the longer hold.
  always_comb
  begin
    limit = 32'h0000_0001;
    unique case (state_q)
      LLD_ST_DETECT    : limit = (level_q == `LLD_LEVEL_LAST) ? LAST_CYC : STEP_CYC;
      LLD_ST_WAIT      : limit = WAIT_CYC;
      LLD_ST_DISCHARGE : limit = DIS_CYC;
      LLD_ST_BLANK     : limit = BLANK_CYC;
      LLD_ST_IDLE,
      LLD_ST_SHORTTEST,
      LLD_ST_OFF       : limit = 32'h0000_0001;
    endcase
  end
  assign timer_done = (timer_q >= (limit - 32'h0000_0001));
  // Next state.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      LLD_ST_IDLE :
        if (sync_q.vdd_on && !vdd_on_prev_q)
        begin
          state_d = LLD_ST_SHORTTEST;
        end
      LLD_ST_SHORTTEST :
        if (run_first)
        begin
          state_d = sync_q.pin_low ? LLD_ST_OFF : LLD_ST_DETECT;
        end
      LLD_ST_DETECT :
        if (lzc_event)
        begin
          state_d = LLD_ST_WAIT;
        end
        else if (timer_done && level_q == `LLD_LEVEL_LAST)
        begin
          state_d = LLD_ST_DISCHARGE;
        end
      LLD_ST_DISCHARGE :
        if (lzc_event)
        begin
          state_d = LLD_ST_WAIT;
        end
        else if (timer_done)
        begin
          state_d = LLD_ST_BLANK;
        end
      LLD_ST_WAIT,
      LLD_ST_BLANK :
        if (timer_done)
        begin
          state_d = LLD_ST_DETECT;
        end
      LLD_ST_OFF :
        state_d = LLD_ST_OFF;
    endcase
  end
  // State register.
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= LLD_ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end
  // Phase timer restarts on every state change and on every staircase step.
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      timer_q <= 32'h0000_0000;
    end
    else if (state_d != state_q || timer_done)
    begin
      timer_q <= 32'h0000_0000;
    end
    else
    begin
      timer_q <= timer_q + 32'h0000_0001;
    end
  end
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      level_q <= `LLD_LEVEL_FIRST;
    end
    else if (state_q != LLD_ST_DETECT)
    begin
      level_q <= `LLD_LEVEL_FIRST;
    end
    else if (!lzc_event && timer_done && level_q != `LLD_LEVEL_LAST)
    begin
      level_q <= level_q + 2'h1;
    end
  end
  // latch set on confirmed loss.
  // Cleared by a later crossing, on the same edge at which it releases the fault latch.
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      loss_q <= 1'b0;
    end
    else if (state_q == LLD_ST_DETECT && state_d == LLD_ST_DISCHARGE)
    begin
      loss_q <= 1'b1;
    end
    else if (lzc_event)
    begin
      loss_q <= 1'b0;
    end
  end

  // disabled mode waits for logic reset.
  assign fault_clr = (state_q == LLD_ST_OFF) ? vdd_rst_event_q
                                             : (vdd_rst_event_q | (loss_q & lzc_event));

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      fault_q <= 1'b0;
    end
    else if (fault_set_i)
    begin
      fault_q <= 1'b1;
    end
    else if (fault_clr)
    begin
      fault_q <= 1'b0;
    end
  end
  always_comb
  begin
    level_ua = 12'(LEVEL0_UA);
    unique case (level_q)
      2'h0 : level_ua = 12'(LEVEL0_UA);
      2'h1 : level_ua = 12'(`LLD_LEVEL1_UA);
      2'h2 : level_ua = 12'(LEVEL2_UA);
      2'h3 : level_ua = 12'(LEVEL3_UA);
    endcase
  end

  // Registered drive; outputs trail the state by one cycle, far below the analog settling time.
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      drive_o <= '0;
    end
    else
    begin
      drive_o.short_src    <= (state_q == LLD_ST_SHORTTEST);
      drive_o.test_en      <= (state_q == LLD_ST_DETECT);
      drive_o.level        <= level_q;
      drive_o.discharge_en <= (state_q == LLD_ST_DISCHARGE);
      unique case (state_q)
        LLD_ST_SHORTTEST : drive_o.current_ua <= 12'(`LLD_SHORT_TEST_UA);
        LLD_ST_DETECT    : drive_o.current_ua <= level_ua;
        LLD_ST_DISCHARGE : drive_o.current_ua <= 12'(`LLD_DISCHARGE_UA);
        LLD_ST_IDLE,
        LLD_ST_WAIT,
        LLD_ST_BLANK,
        LLD_ST_OFF       : drive_o.current_ua <= `LLD_CUR_RST;
      endcase
    end
  end

  // Status outputs straight from registers.
  assign line_loss_latch_o = loss_q;
  assign fault_latch_o     = fault_q;
  assign switching_en_o    = ~fault_q;
  assign supply_cycle_o    = fault_q;
  assign function_off_o    = (state_q == LLD_ST_OFF);
  assign state_o           = state_q;

endmodule : lld_seq
`default_nettype wire

// ### lld_seq_note_end.sv
// Holds no code; every piece of the sequencer logic lives in lld_seq.sv.

// ### lld_seq_properties.sv
// Port-level checks of the line-sense sequencer, bound into the design.
`timescale 1ns/10ps
`default_nettype none
module lld_seq_properties #(
  parameter int unsigned DIS_CYC = 6000000
) (
  // Clock and reset.
  input wire logic                clock_i,
  input wire logic                sys_rst_i,
  // Inputs.
  input wire lld_pkg::lld_pins_t  pins_i,
  input wire logic                fault_set_i,
  // Outputs.
  input wire lld_pkg::lld_drive_t drive_o,
  input wire logic                line_loss_latch_o,
  input wire logic                fault_latch_o,
  input wire logic                switching_en_o,
  input wire logic                supply_cycle_o,
  input wire logic                function_off_o,
  input wire logic [6:0]          state_o
);
  import lld_pkg::*;
  int unsigned dis_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // Counts the burst so its length is bounded without a long repetition.
  always_ff @(posedge clock_i)
    dis_q <= (state_o == LLD_ST_DISCHARGE) ? dis_q + 1 : 0;
  // Steps of a confirmed loss and of a fresh window.
  sequence s_loss;
    state_o == LLD_ST_DETECT ##1 state_o == LLD_ST_DISCHARGE;
  endsequence
  sequence s_rearm;
    state_o != LLD_ST_DETECT ##1 state_o == LLD_ST_DETECT;
  endsequence
  AST_DIS_CAUSE: assert property (drive_o.discharge_en |->
    $past(state_o) == LLD_ST_DISCHARGE && drive_o.current_ua == 12'h7D0)
    else $error("discharge outside its state or at the wrong current");
  AST_DIS_MAX: assert property (dis_q <= DIS_CYC)
    else $error("discharge burst too long");
  AST_QUIET: assert property ((state_o == LLD_ST_WAIT || state_o == LLD_ST_BLANK) &&
    $stable(state_o) |-> drive_o.current_ua == 12'h000 && !drive_o.test_en)
    else $error("current during wait or blanking");
  AST_LOSS_SET: assert property (s_loss |-> line_loss_latch_o)
    else $error("loss latch not set on entering discharge");
  AST_LEVEL1: assert property (drive_o.test_en && drive_o.level == 2'h1 |->
    drive_o.current_ua == 12'h307)
    else $error("second level current wrong");
  AST_SHORT: assert property (drive_o.short_src |->
    drive_o.current_ua == 12'h050 && $past(state_o) == LLD_ST_SHORTTEST)
    else $error("short test source wrong");
  AST_OFF_QUIET: assert property (function_off_o && $past(function_off_o) |-> drive_o == '0)
    else $error("current while function is off");
  AST_FAULT: assert property (fault_set_i |=> fault_latch_o)
    else $error("fault latch not set");
  AST_SWITCH: assert property (switching_en_o == !fault_latch_o && supply_cycle_o == fault_latch_o)
    else $error("switching not tied to fault latch");
  AST_REARM: assert property (s_rearm |=> drive_o.test_en && drive_o.level == 2'h0)
    else $error("window does not start at lowest level");
endmodule : lld_seq_properties
bind lld_seq lld_seq_properties #(.DIS_CYC(DIS_CYC)) lld_seq_properties_i (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .pins_i(pins_i), .fault_set_i(fault_set_i),
  .drive_o(drive_o), .line_loss_latch_o(line_loss_latch_o), .fault_latch_o(fault_latch_o),
  .switching_en_o(switching_en_o), .supply_cycle_o(supply_cycle_o),
  .function_off_o(function_off_o), .state_o(state_o));
`default_nettype wire

// ### lld_line_model.sv
// Behavioural mains sensing network on the line-sense pins.
`timescale 1ns/10ps
`default_nettype none
module lld_line_model (
  // Test setup.
  input wire logic                line_on_i,
  input wire logic                short_i,
  input wire logic [1:0]          need_i,
  // Device drive.
  input wire lld_pkg::lld_drive_t drive_i,
  // Comparator levels.
  output logic                    lzc_o,
  output logic                    pin_low_o
);
  // crossing needs current
  // Diode leakage keeps the pin under the threshold until the sunk current is high enough.
  assign lzc_o = line_on_i & (drive_i.discharge_en | (drive_i.test_en & (drive_i.level >= need_i)));
  // low without source
  // An unsourced pin reads low, so a device that judges too early is caught.
  assign pin_low_o = short_i | ~drive_i.short_src;
endmodule : lld_line_model
`default_nettype wire

// ### tb_lld_seq.sv
// Self-checking bench of the line-loss discharge sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb_lld_seq;
  import lld_pkg::*;
  // A row: line present, level it needs, and the state and latch that follow.
  typedef struct {logic line; logic [1:0] need; logic [6:0] st; logic loss;} lld_row_t;
  localparam int unsigned DIS = 25;
  localparam int unsigned BLK = 60;
  lld_row_t rows [5] = '{'{1'b1, 2'h0, LLD_ST_WAIT, 1'b0}, '{1'b1, 2'h1, LLD_ST_WAIT, 1'b0},
    '{1'b1, 2'h2, LLD_ST_WAIT, 1'b0}, '{1'b1, 2'h3, LLD_ST_WAIT, 1'b0},
    '{1'b0, 2'h3, LLD_ST_DISCHARGE, 1'b1}};
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic fault_set_i = 1'b0;
  logic run = 1'b0, vdd_on = 1'b0, vdd_rst = 1'b0, line_on = 1'b0, pin_short = 1'b0;
  logic [1:0] need = 2'h0, lvl = 2'h0;
  logic line_zero_cross_detect, pin_low, loss, fault, sw_en, cyc, off;
  lld_drive_t drive_o;
  logic [6:0] state_o;
  int fails = 0, checked = 0, k;
  always #25 clock_i = ~clock_i;
  // Last staircase index that carried current.
  always @(posedge clock_i) if (drive_o.test_en === 1'b1) lvl <= drive_o.level;
  lld_seq #(.STEP_CYC(10), .LAST_CYC(40), .DIS_CYC(DIS), .BLANK_CYC(BLK), .WAIT_CYC(60)) lld_seq_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .pins_i(lld_pins_t'({run, vdd_rst, vdd_on, pin_low, line_zero_cross_detect})),
    .fault_set_i(fault_set_i), .drive_o(drive_o), .line_loss_latch_o(loss), .fault_latch_o(fault),
    .switching_en_o(sw_en), .supply_cycle_o(cyc), .function_off_o(off), .state_o(state_o));
  lld_line_model lld_line_model_i (.line_on_i(line_on), .short_i(pin_short), .need_i(need),
    .drive_i(drive_o), .lzc_o(line_zero_cross_detect), .pin_low_o(pin_low));
  task automatic note(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : note
  task automatic cmp_b(input logic got, input logic exp);
    note(got === exp, "flag");
  endtask : cmp_b
  task automatic cmp_v(input logic [11:0] got, input logic [11:0] exp);
    note(got === exp, "value");
  endtask : cmp_v
  task automatic cmp_st(input logic [6:0] exp);
    note(state_o === exp, "state");
  endtask : cmp_st
  task automatic wait_st(input logic [6:0] exp);
    for (k = 0; k < 200 && state_o !== exp; k++) @(negedge clock_i);
  endtask : wait_st
  task automatic count_st(input logic [6:0] exp, input logic [11:0] n);
    int c;
    c = 0;
    wait_st(exp);
    while (state_o === exp && c < 300)
    begin
      c++;
      @(negedge clock_i);
    end
    cmp_v(12'(c), n);
  endtask : count_st
  // Reset, supply start, then the first run rise once the short test source has settled.
  task automatic start(input logic sh);
    sys_rst_i = 1'b1;
    vdd_on = 1'b0;
    vdd_rst = 1'b0;
    run = 1'b0;
    pin_short = sh;
    repeat (4) @(negedge clock_i);
    sys_rst_i = 1'b0;
    vdd_on = 1'b1;
    wait_st(LLD_ST_SHORTTEST);
    repeat (4) @(negedge clock_i);
    run = 1'b1;
    wait_st(sh ? LLD_ST_OFF : LLD_ST_DETECT);
  endtask : start
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (6000) @(posedge clock_i);
    fails++;
    stop_test();
  end
  initial
  begin
    foreach (rows[i])
    begin
      line_on = rows[i].line;
      need = rows[i].need;
      start(1'b0);
      wait_st(rows[i].st);
      cmp_st(rows[i].st);
      cmp_b(loss, rows[i].loss);
      cmp_v({10'h0, lvl}, {10'h0, rows[i].need});
      $display("row %0d done", i);
    end
    // Line gone: burst and blanking lengths, re-armed window, fast fault clear on return.
    line_on = 1'b0;
    need = 2'h0;
    start(1'b0);
    count_st(LLD_ST_DISCHARGE, 12'(DIS));
    count_st(LLD_ST_BLANK, 12'(BLK));
    @(negedge clock_i);
    cmp_v({10'h0, drive_o.level}, 12'h000);
    cmp_b(loss, 1'b1);
    fault_set_i = 1'b1;
    @(negedge clock_i);
    fault_set_i = 1'b0;
    cmp_b(fault, 1'b1);
    cmp_b(sw_en, 1'b0);
    cmp_b(cyc, 1'b1);
    line_on = 1'b1;
    wait_st(LLD_ST_WAIT);
    cmp_st(LLD_ST_WAIT);
    cmp_b(fault, 1'b0);
    cmp_b(loss, 1'b0);
    $display("loss test done");
    // Shorted pins: function off, fault cleared only by the supply reset level.
    line_on = 1'b0;
    start(1'b1);
    cmp_st(LLD_ST_OFF);
    @(negedge clock_i);
    cmp_b(off, 1'b1);
    cmp_v(drive_o.current_ua, 12'h000);
    fault_set_i = 1'b1;
    @(negedge clock_i);
    fault_set_i = 1'b0;
    repeat (8) @(negedge clock_i);
    cmp_b(fault, 1'b1);
    vdd_rst = 1'b1;
    repeat (8) @(negedge clock_i);
    cmp_b(fault, 1'b0);
    cmp_st(LLD_ST_OFF);
    $display("short test done");
    // A reset in mid-run with the fault set returns everything to idle.
    fault_set_i = 1'b1;
    @(negedge clock_i);
    fault_set_i = 1'b0;
    sys_rst_i = 1'b1;
    repeat (4) @(negedge clock_i);
    cmp_st(LLD_ST_IDLE);
    cmp_b(fault, 1'b0);
    cmp_b(sw_en, 1'b1);
    cmp_b(|drive_o, 1'b0);
    $display("reset test done");
    stop_test();
  end
endmodule : tb_lld_seq
`default_nettype wire
